// file: core/aeh_pkg.sv
package aeh_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int STANDBY_TIME_MS = 2000;
	localparam int STANDBY_CYCLES = CLK_HZ / 1000 * STANDBY_TIME_MS;

	// ==========================================================
	// Axis parameter numbers
	localparam logic [7:0] PAR_ACT_POS = 8'h01;
	localparam logic [7:0] PAR_MOVE_PERIOD = 8'h04;
	localparam logic [7:0] PAR_MRES = 8'h8c;
	localparam logic [7:0] PAR_RS_MODE = 8'hc1;
	localparam logic [7:0] PAR_RS_SPEED = 8'hc2;
	localparam logic [7:0] PAR_RS_CAL = 8'hc3;
	localparam logic [7:0] PAR_RS_DIST = 8'hc4;
	localparam logic [7:0] PAR_INT_ENC = 8'hd1;
	localparam logic [7:0] PAR_CLR_NULL = 8'hd2;
	localparam logic [7:0] PAR_INT_MAXDEV = 8'hd4;
	localparam logic [7:0] PAR_ANGLE = 8'hd7;
	localparam logic [7:0] PAR_EXT_ENC = 8'hd8;
	localparam logic [7:0] PAR_EXT_CPR = 8'hd9;
	localparam logic [7:0] PAR_EXT_MAXDEV = 8'hda;
	localparam logic [7:0] PAR_SD_MODE = 8'hfe;

	// ==========================================================
	// Field layouts and reset values
	localparam logic [3:0] MRES_RST = 4'h8;
	localparam logic [3:0] MRES_MAX = 4'h8;
	localparam int INT_FRAC = 10;
	localparam int EXT_FRAC = 16;
	localparam int RS_FLIP_BIT = 6;
	localparam int RS_INV_BIT = 7;
	localparam logic [5:0] RS_BASE_MAX = 6'h08;
	localparam logic [7:0] RS_MODE_RST = 8'h01;
	localparam logic [31:0] MOVE_PERIOD_RST = 32'h0000_0100;
	localparam logic [31:0] RS_SPEED_RST = 32'h0000_0200;
	localparam logic [31:0] RS_CAL_RST = 32'h0000_1000;
	localparam logic [31:0] EXT_CPR_RST = 32'h0000_1000;
	localparam logic [1:0] RFS_START = 2'h0;
	localparam logic [1:0] RFS_STOP = 2'h1;
	localparam logic [1:0] RFS_STATUS = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [7:0] {
		ROTATE_RIGHT_CMD = 8'h01,
		ROTATE_LEFT_CMD = 8'h02,
		MOTOR_HALT_CMD = 8'h03,
		MOVE_TO_POSITION_CMD = 8'h04,
		SET_AXIS_PARAM_CMD = 8'h05,
		GET_AXIS_PARAM_CMD = 8'h06,
		REFERENCE_SEARCH_CMD = 8'h0d
	} aeh_op_t;

	typedef enum logic [5:0] {
		RS_IDLE = 6'b000001,
		RS_SEEK = 6'b000010,
		RS_SEEK2 = 6'b000100,
		RS_LEAVE = 6'b001000,
		RS_REENTER = 6'b010000,
		RS_FINISH = 6'b100000
	} aeh_rs_t;

	typedef enum logic [2:0] {
		MV_IDLE = 3'b001,
		MV_ROT = 3'b010,
		MV_POS = 3'b100
	} aeh_mv_t;

	typedef struct packed {
		aeh_op_t op;
		logic [7:0] param;
		logic [31:0] value;
	} aeh_cmd_t;

	typedef struct packed {
		logic [9:0] angle;
		logic extA;
		logic extB;
		logic swLeft;
		logic swRight;
		logic swHome;
		logic sdStep;
		logic sdDir;
	} aeh_field_t;

	typedef struct packed {
		logic refBusy;
		logic devError;
		logic sdMode;
		logic runCurrent;
	} aeh_status_t;
endpackage

// file: core/aeh_param_mem.sv
module aeh_param_mem #(
	parameter int AW = 8,
	parameter int DW = 32
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Write side
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	// Read side
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData_r
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	if (AW < 1 || DW < 1) begin : gChk
		$error("aeh_param_mem: bad geometry");
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_r <= '0;
		end else begin
			rdData_r <= mem[rdAddr];
		end
	end
endmodule // aeh_param_mem

// file: core/aeh_axis_control.sv
module aeh_axis_control #(
	parameter int FULL_STEPS = 200,
	parameter int STANDBY_CYC = aeh_pkg::STANDBY_CYCLES
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Host command port
	input wire logic cmdValid,
	input aeh_pkg::aeh_cmd_t cmd,
	output logic respValid,
	output logic [31:0] respData,
	input wire logic devClear,
	// Field side
	input aeh_pkg::aeh_field_t field,
	output logic stepOut,
	output logic dirOut,
	output aeh_pkg::aeh_status_t status
);
	import aeh_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (FULL_STEPS < 1 || FULL_STEPS > 255 || STANDBY_CYC < 1) begin : gChk
		$error("aeh_axis_control: unsupported parameter");
	end

	// ==========================================================
	// State
	typedef struct packed {
		aeh_field_t sync1;
		aeh_field_t sync2;
		aeh_field_t prev;
		logic [3:0] mres;
		logic [15:0] intScale;
		logic [31:0] extScale;
		logic [41:0] intAcc;
		logic [47:0] extAcc;
		logic clrNull;
		logic [31:0] intMaxDev;
		logic [31:0] extMaxDev;
		logic [31:0] extCpr;
		logic sdMode;
		logic [31:0] pos;
		logic [31:0] target;
		logic [31:0] movePeriod;
		logic [31:0] stepCnt;
		aeh_mv_t mv;
		logic mvDir;
		aeh_rs_t rs;
		logic [7:0] rsMode;
		logic rsDir;
		logic [31:0] rsSpeed;
		logic [31:0] rsCal;
		logic [31:0] rsDist;
		logic [31:0] rsP2;
		logic [31:0] rsPa;
		logic [31:0] rsRef;
		logic devError;
		logic [5:0] divCnt;
		logic [32:0] divRem;
		logic [31:0] divQ;
		logic [31:0] divNum;
		logic stepOut;
		logic dirOut;
		logic [31:0] idleCnt;
		logic runCur;
		logic pend;
		aeh_op_t pendOp;
		logic [7:0] pendParam;
		logic [31:0] pendVal;
		logic respValid;
		logic [31:0] respData;
	} aeh_state_t;

	aeh_state_t s_r;
	aeh_state_t s_nxt;
	logic [31:0] memRdData;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] usPerRev(input logic [3:0] m);
		return 16'(FULL_STEPS << m);
	endfunction

	function automatic logic [31:0] absDiff(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] d;
		d = {a[31], a} - {b[31], b};
		return d[32] ? 32'(-d) : d[31:0];
	endfunction

	function automatic logic overLimit(input logic [31:0] a, input logic [31:0] b, input logic [31:0] lim);
		return (lim != 32'h0) && (absDiff(a, b) > lim);
	endfunction

	function automatic logic [31:0] midpoint(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] sum;
		sum = {a[31], a} + {b[31], b};
		return sum[32:1];
	endfunction

	// Returns {valid, up}; an illegal double change is dropped
	function automatic logic [1:0] quadStep(input logic pa, input logic pb, input logic ca, input logic cb);
		logic chg;
		chg = (pa ^ ca) ^ (pb ^ cb);
		return {chg, pa ^ cb};
	endfunction

	// ==========================================================
	// Parameter store for numbers this block does not act on
	aeh_param_mem #(
		.AW(8),
		.DW(32)
	) uMem (
		.clk(clk),
		.rst(rst),
		.wrEn(cmdValid && cmd.op == SET_AXIS_PARAM_CMD),
		.wrAddr(cmd.param),
		.wrData(cmd.value),
		.rdAddr(cmd.param),
		.rdData_r(memRdData)
	);

	// ==========================================================
	// Next state
	logic [9:0] angleDelta;
	logic signed [26:0] prod;
	logic nullEvt;
	logic [1:0] quad;
	logic [5:0] base;
	logic flip;
	logic swNear;
	logic swFar;
	logic calSw;
	logic seekSw;
	logic moveOn;
	logic moveDir;
	logic [31:0] movePer;
	logic stepNow;
	logic divStart;
	logic [32:0] divTry;
	logic [31:0] mid;

	always_comb begin
		s_nxt = s_r;
		divStart = 1'b0;
		mid = 32'h0;
		s_nxt.sync1 = field;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		s_nxt.stepOut = 1'b0;

		// Internal encoder: angle steps scaled to microsteps with a fraction
		angleDelta = s_r.sync2.angle - s_r.prev.angle;
		prod = $signed(angleDelta) * $signed({1'b0, s_r.intScale});
		s_nxt.intAcc = s_r.intAcc + {{15{prod[26]}}, prod};
		nullEvt = (s_r.prev.angle[9:8] == 2'h3 && s_r.sync2.angle[9:8] == 2'h0) ||
			(s_r.prev.angle[9:8] == 2'h0 && s_r.sync2.angle[9:8] == 2'h3);
		if (nullEvt && s_r.clrNull) begin
			s_nxt.intAcc = '0;
			s_nxt.clrNull = 1'b0;
		end

		// External quadrature encoder
		quad = quadStep(s_r.prev.extA, s_r.prev.extB, s_r.sync2.extA, s_r.sync2.extB);
		if (quad[1]) begin
			s_nxt.extAcc = quad[0] ? s_r.extAcc + {16'h0, s_r.extScale} : s_r.extAcc - {16'h0, s_r.extScale};
		end

		// Prescaler divider, one quotient bit a cycle
		divTry = {s_r.divRem[31:0], s_r.divNum[31]};
		if (s_r.divCnt != 6'h0) begin
			s_nxt.divNum = {s_r.divNum[30:0], 1'b0};
			s_nxt.divCnt = s_r.divCnt - 6'h1;
			if (divTry >= {1'b0, s_r.extCpr}) begin
				s_nxt.divRem = divTry - {1'b0, s_r.extCpr};
				s_nxt.divQ = {s_r.divQ[30:0], 1'b1};
			end else begin
				s_nxt.divRem = divTry;
				s_nxt.divQ = {s_r.divQ[30:0], 1'b0};
			end
			if (s_r.divCnt == 6'h1) begin
				s_nxt.extScale = (s_r.extCpr == 32'h0) ? 32'h0 : s_nxt.divQ;
			end
		end

		// Motion request: search owns the motor while it runs
		base = s_r.rsMode[5:0];
		flip = s_r.rsMode[RS_FLIP_BIT];
		swNear = flip ? s_r.sync2.swRight : s_r.sync2.swLeft;
		swFar = flip ? s_r.sync2.swLeft : s_r.sync2.swRight;
		calSw = (base >= 6'h5) ? (s_r.sync2.swHome ^ s_r.rsMode[RS_INV_BIT]) : swNear;
		seekSw = (base == 6'h2 || base == 6'h3) ? swFar : calSw;
		moveOn = 1'b0;
		moveDir = s_r.rsDir;
		movePer = s_r.rsSpeed;
		case (s_r.rs)
			RS_SEEK, RS_SEEK2: begin
				moveOn = 1'b1;
			end
			RS_LEAVE, RS_REENTER: begin
				moveOn = 1'b1;
				movePer = s_r.rsCal;
			end
			RS_IDLE: begin
				moveDir = s_r.mvDir;
				movePer = s_r.movePeriod;
				if (s_r.mv == MV_ROT) begin
					moveOn = 1'b1;
				end else if (s_r.mv == MV_POS) begin
					moveOn = s_r.pos != s_r.target;
					moveDir = $signed(s_r.target) > $signed(s_r.pos);
					if (!moveOn) begin
						s_nxt.mv = MV_IDLE;
					end
				end
			end
			default: begin
				moveOn = 1'b0;
			end
		endcase

		// Step engine, or the external step input in step/direction mode
		stepNow = 1'b0;
		if (s_r.sdMode) begin
			stepNow = s_r.sync2.sdStep && !s_r.prev.sdStep;
			moveDir = s_r.sync2.sdDir;
			s_nxt.stepCnt = 32'h0;
		end else if (moveOn) begin
			stepNow = s_r.stepCnt == 32'h0;
			s_nxt.stepCnt = stepNow ? ((movePer == 32'h0) ? 32'h0 : movePer - 32'h1) : s_r.stepCnt - 32'h1;
		end else begin
			s_nxt.stepCnt = 32'h0;
		end
		if (stepNow) begin
			s_nxt.stepOut = 1'b1;
			s_nxt.dirOut = moveDir;
			s_nxt.pos = moveDir ? s_r.pos + 32'h1 : s_r.pos - 32'h1;
		end

		// Run/standby current switching follows step activity in every mode
		if (stepNow) begin
			s_nxt.idleCnt = 32'h0;
		end else if (s_r.idleCnt < 32'(STANDBY_CYC)) begin
			s_nxt.idleCnt = s_r.idleCnt + 32'h1;
		end
		s_nxt.runCur = s_nxt.idleCnt < 32'(STANDBY_CYC);

		// Reference search; end switch stop enables are not consulted here
		case (s_r.rs)
			RS_SEEK: begin
				if (base == 6'h5 && !s_r.rsDir && s_r.sync2.swLeft) begin
					s_nxt.rsDir = 1'b1;
				end else if (base == 6'h6 && s_r.rsDir && s_r.sync2.swRight) begin
					s_nxt.rsDir = 1'b0;
				end
				if (seekSw) begin
					if (base == 6'h2 || base == 6'h3) begin
						s_nxt.rsP2 = s_r.pos;
						s_nxt.rsDir = flip;
						s_nxt.rs = RS_SEEK2;
					end else if (base == 6'h1) begin
						s_nxt.rsRef = s_r.pos;
						s_nxt.rs = RS_FINISH;
					end else begin
						s_nxt.rsPa = s_r.pos;
						s_nxt.rs = RS_LEAVE;
					end
				end
			end
			RS_SEEK2: begin
				if (swNear) begin
					if (base == 6'h2) begin
						s_nxt.rsDist = absDiff(s_r.rsP2, s_r.pos);
						s_nxt.rsRef = s_r.pos;
						s_nxt.rs = RS_FINISH;
					end else begin
						s_nxt.rsPa = s_r.pos;
						s_nxt.rs = RS_LEAVE;
					end
				end
			end
			RS_LEAVE: begin
				if (!calSw) begin
					s_nxt.rsDir = !s_r.rsDir;
					s_nxt.rs = RS_REENTER;
				end
			end
			RS_REENTER: begin
				if (calSw) begin
					mid = midpoint(s_r.rsPa, s_r.pos);
					s_nxt.rsRef = mid;
					if (base == 6'h3) begin
						s_nxt.rsDist = absDiff(s_r.rsP2, mid);
					end
					s_nxt.rs = RS_FINISH;
				end
			end
			RS_FINISH: begin
				s_nxt.pos = s_r.pos - s_r.rsRef;
				s_nxt.rs = RS_IDLE;
			end
			default: begin
				s_nxt.rs = RS_IDLE;
			end
		endcase

		// Host commands
		s_nxt.pend = cmdValid;
		if (cmdValid) begin
			s_nxt.pendOp = cmd.op;
			s_nxt.pendParam = cmd.param;
			s_nxt.pendVal = cmd.value;
			case (cmd.op)
				ROTATE_RIGHT_CMD, ROTATE_LEFT_CMD: begin
					if (!s_r.sdMode && s_r.rs == RS_IDLE) begin
						s_nxt.mv = MV_ROT;
						s_nxt.mvDir = cmd.op == ROTATE_RIGHT_CMD;
					end
				end
				MOTOR_HALT_CMD: begin
					if (!s_r.sdMode) begin
						s_nxt.mv = MV_IDLE;
						s_nxt.rs = RS_IDLE;
					end
				end
				MOVE_TO_POSITION_CMD: begin
					if (!s_r.sdMode && s_r.rs == RS_IDLE) begin
						s_nxt.mv = MV_POS;
						s_nxt.target = cmd.value;
					end
				end
				REFERENCE_SEARCH_CMD: begin
					if (cmd.value[1:0] == RFS_START && !s_r.sdMode && base >= 6'h1 && base <= RS_BASE_MAX) begin
						s_nxt.rs = RS_SEEK;
						s_nxt.mv = MV_IDLE;
						s_nxt.rsDir = (base == 6'h1 || base == 6'h4) ? flip :
							(base == 6'h2 || base == 6'h3) ? !flip :
							(base == 6'h6 || base == 6'h7);
					end else if (cmd.value[1:0] == RFS_STOP) begin
						s_nxt.rs = RS_IDLE;
					end
				end
				SET_AXIS_PARAM_CMD: begin
					if (cmd.param == PAR_ACT_POS) begin
						s_nxt.pos = cmd.value;
					end else if (cmd.param == PAR_MOVE_PERIOD) begin
						s_nxt.movePeriod = cmd.value;
					end else if (cmd.param == PAR_MRES) begin
						if (cmd.value <= {28'h0, MRES_MAX}) begin
							s_nxt.mres = cmd.value[3:0];
							s_nxt.intScale = usPerRev(cmd.value[3:0]);
							divStart = 1'b1;
						end
					end else if (cmd.param == PAR_RS_MODE) begin
						s_nxt.rsMode = cmd.value[7:0];
					end else if (cmd.param == PAR_RS_SPEED) begin
						s_nxt.rsSpeed = cmd.value;
					end else if (cmd.param == PAR_RS_CAL) begin
						s_nxt.rsCal = cmd.value;
					end else if (cmd.param == PAR_INT_ENC) begin
						s_nxt.intAcc = {cmd.value, 10'h0};
					end else if (cmd.param == PAR_CLR_NULL) begin
						s_nxt.clrNull = cmd.value[0];
					end else if (cmd.param == PAR_INT_MAXDEV) begin
						s_nxt.intMaxDev = cmd.value;
					end else if (cmd.param == PAR_EXT_ENC) begin
						s_nxt.extAcc = {cmd.value, 16'h0};
					end else if (cmd.param == PAR_EXT_CPR) begin
						s_nxt.extCpr = cmd.value;
						divStart = 1'b1;
					end else if (cmd.param == PAR_EXT_MAXDEV) begin
						s_nxt.extMaxDev = cmd.value;
					end else if (cmd.param == PAR_SD_MODE) begin
						s_nxt.sdMode = cmd.value[0];
						if (cmd.value[0]) begin
							s_nxt.mv = MV_IDLE;
							s_nxt.rs = RS_IDLE;
						end
					end
				end
				default: begin
					s_nxt.pendOp = cmd.op;
				end
			endcase
		end
		if (divStart) begin
			s_nxt.divNum = {usPerRev(s_nxt.mres), 16'h0};
			s_nxt.divRem = '0;
			s_nxt.divQ = '0;
			s_nxt.divCnt = 6'h20;
		end

		// Deviation supervision wins over host and search motion requests, not over the external step input
		if (devClear) begin
			s_nxt.devError = 1'b0;
		end
		if (overLimit(s_r.pos, s_r.intAcc[41:10], s_r.intMaxDev) ||
			overLimit(s_r.pos, s_r.extAcc[47:16], s_r.extMaxDev)) begin
			s_nxt.devError = 1'b1;
			s_nxt.mv = MV_IDLE;
			s_nxt.rs = RS_IDLE;
			s_nxt.stepCnt = 32'h0;
		end

		// Answer one cycle after the parameter store has been read
		s_nxt.respValid = s_r.pend;
		if (s_r.pend) begin
			if (s_r.pendOp == GET_AXIS_PARAM_CMD) begin
				if (s_r.pendParam == PAR_ACT_POS) begin
					s_nxt.respData = s_r.pos;
				end else if (s_r.pendParam == PAR_MOVE_PERIOD) begin
					s_nxt.respData = s_r.movePeriod;
				end else if (s_r.pendParam == PAR_MRES) begin
					s_nxt.respData = {28'h0, s_r.mres};
				end else if (s_r.pendParam == PAR_RS_MODE) begin
					s_nxt.respData = {24'h0, s_r.rsMode};
				end else if (s_r.pendParam == PAR_RS_SPEED) begin
					s_nxt.respData = s_r.rsSpeed;
				end else if (s_r.pendParam == PAR_RS_CAL) begin
					s_nxt.respData = s_r.rsCal;
				end else if (s_r.pendParam == PAR_RS_DIST) begin
					s_nxt.respData = s_r.rsDist;
				end else if (s_r.pendParam == PAR_INT_ENC) begin
					s_nxt.respData = s_r.intAcc[41:10];
				end else if (s_r.pendParam == PAR_CLR_NULL) begin
					s_nxt.respData = {31'h0, s_r.clrNull};
				end else if (s_r.pendParam == PAR_INT_MAXDEV) begin
					s_nxt.respData = s_r.intMaxDev;
				end else if (s_r.pendParam == PAR_ANGLE) begin
					s_nxt.respData = {22'h0, s_r.sync2.angle};
				end else if (s_r.pendParam == PAR_EXT_ENC) begin
					s_nxt.respData = s_r.extAcc[47:16];
				end else if (s_r.pendParam == PAR_EXT_CPR) begin
					s_nxt.respData = s_r.extCpr;
				end else if (s_r.pendParam == PAR_EXT_MAXDEV) begin
					s_nxt.respData = s_r.extMaxDev;
				end else if (s_r.pendParam == PAR_SD_MODE) begin
					s_nxt.respData = {31'h0, s_r.sdMode};
				end else begin
					s_nxt.respData = memRdData;
				end
			end else if (s_r.pendOp == REFERENCE_SEARCH_CMD && s_r.pendVal[1:0] == RFS_STATUS) begin
				s_nxt.respData = {31'h0, s_r.rs != RS_IDLE};
			end else begin
				s_nxt.respData = s_r.pendVal;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.mres <= MRES_RST;
			s_r.intScale <= usPerRev(MRES_RST);
			s_r.divNum <= {usPerRev(MRES_RST), 16'h0};
			s_r.divCnt <= 6'h20;
			s_r.extCpr <= EXT_CPR_RST;
			s_r.movePeriod <= MOVE_PERIOD_RST;
			s_r.rsSpeed <= RS_SPEED_RST;
			s_r.rsCal <= RS_CAL_RST;
			s_r.rsMode <= RS_MODE_RST;
			s_r.mv <= MV_IDLE;
			s_r.rs <= RS_IDLE;
			s_r.pendOp <= GET_AXIS_PARAM_CMD;
			s_r.idleCnt <= 32'(STANDBY_CYC);
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign respValid = s_r.respValid;
	assign respData = s_r.respData;
	assign stepOut = s_r.stepOut;
	assign dirOut = s_r.dirOut;
	assign status = '{refBusy: s_r.rs != RS_IDLE, devError: s_r.devError, sdMode: s_r.sdMode, runCurrent: s_r.runCur};
endmodule // aeh_axis_control

// file: bench/aeh_axis_asserts.sv
module aeh_axis_asserts (
	// System
	input wire logic clk,
	input wire logic rst,
	// Host side
	input wire logic cmdValid,
	input aeh_pkg::aeh_cmd_t cmd,
	input wire logic respValid,
	input wire logic [31:0] respData,
	input wire logic devClear,
	// Field side
	input aeh_pkg::aeh_field_t field,
	input wire logic stepOut,
	input aeh_pkg::aeh_status_t status
);
	timeunit 1ns;
	timeprecision 1ns;
	import aeh_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Helpers
	logic [2:0] quiet_r;
	logic [3:0] rfsHist_r;
	logic isGet;
	logic isRfs;
	assign isGet = cmdValid && cmd.op == GET_AXIS_PARAM_CMD;
	assign isRfs = cmdValid && cmd.op == REFERENCE_SEARCH_CMD;
	// Synced pins act after three edges, seven quiet cycles leave margin
	always_ff @(posedge clk) begin
		if (rst) begin
			quiet_r <= 3'h0;
			rfsHist_r <= 4'h0;
		end else begin
			quiet_r <= $changed(field.sdStep) ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
			rfsHist_r <= {rfsHist_r[2:0], isRfs && cmd.value == 32'h0};
		end
	end
	// ==========================================
	// Properties
	property p_resp_time; cmdValid |-> ##2 respValid; endproperty
	a_resp_time: assert property (p_resp_time) else $error("answer late");
	property p_angle; isGet && cmd.param == PAR_ANGLE |-> ##2 respData[31:10] == 22'h0; endproperty
	a_angle: assert property (p_angle) else $error("angle out of range");
	property p_mres; isGet && cmd.param == PAR_MRES |-> ##2 respData <= 32'h8; endproperty
	a_mres: assert property (p_mres) else $error("resolution code too large");
	property p_dev_hold; status.devError && !devClear |=> status.devError; endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("error flag dropped");
	property p_dev_stop; $rose(status.devError) |-> ##[0:3] !status.refBusy; endproperty
	a_dev_stop: assert property (p_dev_stop) else $error("search kept running");
	property p_sd_enter;
		cmdValid && cmd.op == SET_AXIS_PARAM_CMD && cmd.param == PAR_SD_MODE && cmd.value == 32'h1
			|-> ##[1:3] status.sdMode;
	endproperty
	a_sd_enter: assert property (p_sd_enter) else $error("step mode not entered");
	property p_sd_quiet; status.sdMode && quiet_r == 3'h7 |-> !stepOut; endproperty
	a_sd_quiet: assert property (p_sd_quiet) else $error("step without step input");
	property p_rfs_stop; isRfs && cmd.value == 32'h1 |-> ##[1:3] !status.refBusy; endproperty
	a_rfs_stop: assert property (p_rfs_stop) else $error("search not stopped");
	property p_rfs_rise; $rose(status.refBusy) |-> rfsHist_r != 4'h0; endproperty
	a_rfs_rise: assert property (p_rfs_rise) else $error("search started unasked");
	c_sd_step: cover property (status.sdMode && stepOut);
	c_dev: cover property ($rose(status.devError));
	c_ref_done: cover property ($fell(status.refBusy));
endmodule // aeh_axis_asserts

bind aeh_axis_control aeh_axis_asserts chk (.clk, .rst, .cmdValid, .cmd, .respValid, .respData, .devClear,
	.field, .stepOut, .status);

// file: bench/aeh_host_model.sv
module aeh_host_model (
	// System
	input wire logic clk,
	// Command port
	output logic cmdValid,
	output aeh_pkg::aeh_cmd_t cmd,
	input wire logic respValid,
	input wire logic [31:0] respData
);
	timeunit 1ns;
	timeprecision 1ns;
	import aeh_pkg::*;
	logic [31:0] rd;
	initial begin
		cmdValid = 1'b0;
		cmd = '0;
	end
	task automatic xfer(input aeh_op_t op, input logic [7:0] p, input logic [31:0] v);
		int n;
		@(negedge clk);
		cmdValid = 1'b1;
		cmd = '{op, p, v};
		@(negedge clk);
		cmdValid = 1'b0;
		// Idle bus shows the inverse so a stale command is never mistaken for a fresh one
		cmd = ~cmd;
		for (n = 0; n < 4 && respValid !== 1'b1; n++) @(negedge clk);
		rd = respValid === 1'b1 ? respData : ~respData;
	endtask
endmodule // aeh_host_model

// file: bench/testbench.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import aeh_pkg::*;
	logic clk, rst, devClear, respValid, stepOut, dirOut, cmdValid;
	logic [31:0] respData;
	logic [7:0] p, q;
	logic homeInv;
	aeh_cmd_t cmd;
	aeh_field_t field;
	aeh_status_t status;
	int errors, num_checks, s, i, k;
	int stepCnt = 0;
	int zLo = 1 << 30;
	int zHi = 1 << 30;
	aeh_axis_control #(.STANDBY_CYC(20)) dut (.clk, .rst, .cmdValid, .cmd, .respValid, .respData, .devClear,
		.field, .stepOut, .dirOut, .status);
	aeh_host_model host (.clk, .cmdValid, .cmd, .respValid, .respData);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Home switch follows the observed shaft position, as a real cam would
	always @(posedge clk) if (stepOut === 1'b1) stepCnt <= stepCnt + (dirOut ? 1 : -1);
	always @(negedge clk) field.swHome <= homeInv ^ (stepCnt >= zLo && stepCnt <= zHi);
	// ==========================================
	// Access tasks
	task automatic set_axis_param_cmd(input logic [7:0] a, input logic [31:0] v);
		host.xfer(SET_AXIS_PARAM_CMD, a, v);
	endtask
	task automatic get_axis_param_cmd(input logic [7:0] a, input logic [31:0] e);
		host.xfer(GET_AXIS_PARAM_CMD, a, 32'h0);
		`CHK(host.rd, e)
	endtask
	task automatic reference_search_cmd(input logic [1:0] v);
		host.xfer(REFERENCE_SEARCH_CMD, 8'h0, {30'h0, v});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict;
	end
	// ==========================================
	// Tests
	initial begin
		rst = 1'b1;
		devClear = 1'b0;
		homeInv = 1'b0;
		field = '0;
		cyc(5);
		rst = 1'b0;
		cyc(40);
		`CHK(status, 4'h0)
		get_axis_param_cmd(PAR_MRES, 32'h8);
		set_axis_param_cmd(PAR_MRES, 32'h9);
		get_axis_param_cmd(PAR_MRES, 32'h8);
		get_axis_param_cmd(PAR_RS_MODE, 32'h1);
		$display("test reset done");
		for (i = 0; i < 2; i++) begin
			p = i ? PAR_EXT_ENC : PAR_INT_ENC;
			set_axis_param_cmd(p, 32'h8000_0000 - i);
			get_axis_param_cmd(p, 32'h8000_0000 - i);
		end
		for (i = 0; i < 2; i++) begin
			set_axis_param_cmd(PAR_MRES, i ? 32'h8 : 32'h4);
			set_axis_param_cmd(PAR_INT_ENC, 32'h0);
			field.angle = field.angle + 10'h8;
			cyc(6);
			get_axis_param_cmd(PAR_INT_ENC, i ? 32'd400 : 32'd25);
		end
		field.angle = 10'h3ff;
		cyc(6);
		get_axis_param_cmd(PAR_ANGLE, 32'h3ff);
		set_axis_param_cmd(PAR_INT_ENC, 32'h1234);
		set_axis_param_cmd(PAR_CLR_NULL, 32'h1);
		get_axis_param_cmd(PAR_CLR_NULL, 32'h1);
		field.angle = 10'h2;
		cyc(6);
		get_axis_param_cmd(PAR_CLR_NULL, 32'h0);
		host.xfer(GET_AXIS_PARAM_CMD, PAR_INT_ENC, 32'h0);
		`CHK(host.rd < 32'd200, 1'b1)
		// One revolution of counts equals one revolution of microsteps, so each edge is one count
		set_axis_param_cmd(PAR_EXT_CPR, 32'd51200);
		cyc(40);
		set_axis_param_cmd(PAR_EXT_ENC, 32'h0);
		for (i = 0; i < 4; i++) begin
			field.extA = i == 1 || i == 2;
			field.extB = i < 2;
			cyc(4);
		end
		get_axis_param_cmd(PAR_EXT_ENC, 32'd4);
		$display("test encoders done");
		for (i = 0; i < 2; i++) begin
			p = i ? PAR_EXT_ENC : PAR_INT_ENC;
			q = i ? PAR_EXT_MAXDEV : PAR_INT_MAXDEV;
			set_axis_param_cmd(p, 32'd100);
			cyc(4);
			`CHK(status.devError, 1'b0)
			set_axis_param_cmd(q, 32'd100);
			cyc(4);
			`CHK(status.devError, 1'b0)
			set_axis_param_cmd(q, 32'd99);
			cyc(4);
			`CHK(status.devError, 1'b1)
			devClear = 1'b1;
			cyc(2);
			`CHK(status.devError, 1'b1)
			set_axis_param_cmd(p, 32'h0);
			cyc(2);
			devClear = 1'b0;
			cyc(2);
			`CHK(status.devError, 1'b0)
			set_axis_param_cmd(q, 32'h0);
		end
		$display("test deviation done");
		set_axis_param_cmd(PAR_MOVE_PERIOD, 32'h4);
		host.xfer(ROTATE_RIGHT_CMD, 8'h0, 32'h0);
		cyc(40);
		host.xfer(MOTOR_HALT_CMD, 8'h0, 32'h0);
		cyc(4);
		get_axis_param_cmd(PAR_ACT_POS, 32'(stepCnt));
		s = stepCnt - 3;
		host.xfer(MOVE_TO_POSITION_CMD, 8'h0, 32'(s));
		cyc(40);
		`CHK(stepCnt, s)
		set_axis_param_cmd(PAR_SD_MODE, 32'h1);
		`CHK(status.sdMode, 1'b1)
		s = stepCnt;
		host.xfer(ROTATE_LEFT_CMD, 8'h0, 32'h0);
		cyc(20);
		`CHK(stepCnt, s)
		field.sdDir = 1'b1;
		for (i = 0; i < 3; i++) begin
			field.sdStep = 1'b1;
			cyc(3);
			field.sdStep = 1'b0;
			cyc(3);
		end
		cyc(4);
		`CHK(stepCnt, s + 3)
		`CHK(status.runCurrent, 1'b1)
		cyc(40);
		`CHK(status.runCurrent, 1'b0)
		set_axis_param_cmd(PAR_SD_MODE, 32'h0);
		$display("test step direction done");
		set_axis_param_cmd(PAR_RS_SPEED, 32'h8);
		set_axis_param_cmd(PAR_RS_CAL, 32'h8);
		for (i = 0; i < 2; i++) begin
			set_axis_param_cmd(PAR_RS_MODE, i ? 32'h9 : 32'h0);
			reference_search_cmd(RFS_START);
			cyc(4);
			`CHK(status.refBusy, 1'b0)
		end
		set_axis_param_cmd(PAR_RS_MODE, 32'd65);
		reference_search_cmd(RFS_START);
		cyc(20);
		`CHK({status.refBusy, dirOut}, 2'b11)
		reference_search_cmd(RFS_STATUS);
		`CHK(host.rd[0], 1'b1)
		reference_search_cmd(RFS_STOP);
		cyc(2);
		`CHK(status.refBusy, 1'b0)
		set_axis_param_cmd(PAR_RS_MODE, 32'd1);
		field.swRight = 1'b1;
		reference_search_cmd(RFS_START);
		cyc(20);
		`CHK(dirOut, 1'b0)
		field.swLeft = 1'b1;
		for (k = 0; k < 3000 && status.refBusy; k++) cyc(1);
		host.xfer(GET_AXIS_PARAM_CMD, PAR_ACT_POS, 32'h0);
		`CHK(host.rd + 32'h1 <= 32'h2, 1'b1)
		// Mode 2: right switch first, then left; distance allows one step of sync lag per side
		set_axis_param_cmd(PAR_RS_MODE, 32'd2);
		field.swLeft = 1'b0;
		field.swRight = 1'b0;
		reference_search_cmd(RFS_START);
		cyc(40);
		`CHK(dirOut, 1'b1)
		field.swRight = 1'b1;
		s = stepCnt;
		cyc(40);
		`CHK(dirOut, 1'b0)
		field.swLeft = 1'b1;
		s = s - stepCnt;
		for (k = 0; k < 3000 && status.refBusy; k++) cyc(1);
		host.xfer(GET_AXIS_PARAM_CMD, PAR_RS_DIST, 32'h0);
		`CHK(host.rd - 32'(s) + 32'h2 <= 32'h4, 1'b1)
		for (i = 0; i < 2; i++) begin
			homeInv = !i;
			zLo = i ? stepCnt - 20 : stepCnt + 10;
			zHi = zLo + 10;
			cyc(2);
			set_axis_param_cmd(PAR_RS_MODE, i ? 32'd8 : 32'd135);
			reference_search_cmd(RFS_START);
			cyc(4);
			for (k = 0; k < 3000 && status.refBusy; k++) cyc(1);
			cyc(4);
			`CHK(status.refBusy, 1'b0)
			host.xfer(GET_AXIS_PARAM_CMD, PAR_ACT_POS, 32'h0);
			`CHK(host.rd - 32'(stepCnt - (zLo + zHi) / 2) + 32'h1 <= 32'h2, 1'b1)
		end
		$display("test reference search done");
		print_verdict;
	end
endmodule // testbench
